// ### src/slpp_top.sv
//////////////////////////////////////////////////////////////////////////
// Functional notes
// - packets open with a size byte counting size, checksum and payload
// - second byte is the payload sum; payload length is size minus two
// - each host packet gets one byte: 0xCC good, 0x33 faulty
// - acknowledge reports reception only, never command validity
// - device packets: optional zeros, then size, checksum, payload, no gaps
// - zero bytes before the host response are ignored
// - first payload byte is the command, parameters follow
// - ping 0x20, three bytes, sets status to success
// - status 0x23 returns one-byte status packet, then host responds
// - download 0x21, 11 bytes: address then count, MSB first
// - download erases the area before answering
// - data 0x24 valid only after download or data; address advances (the code accepts it after any command while a download is open)
// - programming ends once the download count has been received
// - a NAKed data command leaves the program address unchanged
// - run 0x22, seven bytes, address MSB first; ack then jump
// - reset 0x25, three bytes; ack then software reset
// - first serial port used stays the only one until reset
// - serial framing is handled by the port logic outside
//////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module slpp_top
  import slpp_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_uart_rx_valid,
  input wire logic [7:0] i_uart_rx_data,
  output logic o_uart_rx_ready,
  input wire logic i_ssi_rx_valid,
  input wire logic [7:0] i_ssi_rx_data,
  output logic o_ssi_rx_ready,
  output logic o_uart_tx_valid,
  output logic o_ssi_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  output logic o_erase_req,
  output logic [31:0] o_erase_addr,
  output logic [31:0] o_erase_len,
  input wire logic i_erase_done,
  output logic o_prog_valid,
  output slpp_prog_t o_prog,
  input wire logic i_prog_ready,
  input wire logic i_flash_fail,
  output logic o_run,
  output logic [31:0] o_run_addr,
  output logic o_sw_reset,
  output slpp_link_t o_link
);
  typedef enum logic [3:0] {
    S_SIZE, S_SUM, S_PAY, S_EXEC, S_ERASE, S_PROG, S_ACK, S_TXP, S_HRESP
  } slpp_state_t;
  typedef enum logic [1:0] {P_NONE, P_RUN, P_RST, P_TXP} slpp_post_t;

  //////////////////////////////////////////////////////////////////////////
  logic push_valid;
  logic [7:0] push_data;
  logic push_ready;
  logic rx_valid;
  logic [7:0] rx_data;
  wire logic rx_ready;

  slpp_link_sel u_sel (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_uart_rx_valid(i_uart_rx_valid),
    .i_uart_rx_data(i_uart_rx_data),
    .o_uart_rx_ready(o_uart_rx_ready),
    .i_ssi_rx_valid(i_ssi_rx_valid),
    .i_ssi_rx_data(i_ssi_rx_data),
    .o_ssi_rx_ready(o_ssi_rx_ready),
    .o_push_valid(push_valid),
    .o_push_data(push_data),
    .i_push_ready(push_ready),
    .o_link(o_link)
  );

  // the parser stalls during erase and programming, so this fills
  slpp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_valid(push_valid),
    .i_wr_data(push_data),
    .o_wr_ready(push_ready),
    .o_rd_valid(rx_valid),
    .o_rd_data(rx_data),
    .i_rd_ready(rx_ready)
  );

  //////////////////////////////////////////////////////////////////////////
  slpp_state_t st_reg;
  slpp_post_t post_reg;
  logic [7:0] len_reg;
  logic [7:0] hsum_reg;
  logic [7:0] calc_reg;
  logic [7:0] cnt_reg;
  logic [7:0] pay_reg [PAY_DEPTH];
  logic [7:0] stat_reg;
  logic [7:0] tx_reg;
  logic [1:0] tidx_reg;
  logic [31:0] addr_reg;
  logic [31:0] remain_reg;
  logic active_reg;
  logic fail_reg;
  logic erase_reg;
  logic run_reg;
  logic rst_reg;
  logic [31:0] run_addr_reg;
  wire logic rx_take;
  wire logic rx_zero;
  wire logic tx_valid;
  wire logic tx_hs;
  wire logic [7:0] cmd;
  wire logic pkt_good;
  wire logic cmd_ok;
  wire logic last_pay;
  wire logic [7:0] pay_len;
  wire logic [31:0] word_a;
  wire logic [31:0] word_b;
  wire logic prog_more;
  wire logic prog_hs;
  assign rx_ready = (st_reg == S_SIZE) || (st_reg == S_SUM) ||
    (st_reg == S_PAY) || (st_reg == S_HRESP);
  assign rx_take = rx_valid && rx_ready;
  assign rx_zero = (rx_data == 8'h00);
  assign tx_valid = (st_reg == S_ACK) || (st_reg == S_TXP);
  assign tx_hs = tx_valid && i_tx_ready;
  assign o_uart_tx_valid = tx_valid && (o_link == LINK_UART);
  assign o_ssi_tx_valid = tx_valid && (o_link == LINK_SSI);
  assign o_tx_data = tx_reg; // whole bytes; bit framing is the port's
  assign pay_len = len_reg - HDR_LEN;
  assign last_pay = (cnt_reg + 8'h01) == pay_len;
  assign cmd = pay_reg[0];
  // good framing: length in range and wrapping sum matches
  assign pkt_good = (calc_reg == hsum_reg) && (len_reg >= LEN_SHORT) &&
    (pay_len <= MAX_PAY);
  assign cmd_ok = (cmd_len(cmd) == len_reg);
  // parameters travel most significant byte first
  assign word_a = {pay_reg[1], pay_reg[2], pay_reg[3], pay_reg[4]};
  assign word_b = {pay_reg[5], pay_reg[6], pay_reg[7], pay_reg[8]};
  assign prog_more = (cnt_reg < pay_len) && (remain_reg != '0);
  assign prog_hs = o_prog_valid && i_prog_ready;
  assign o_prog_valid = (st_reg == S_PROG) && prog_more;
  assign o_prog = {addr_reg, pay_reg[cnt_reg[3:0]]};
  assign o_erase_req = erase_reg;
  assign o_erase_addr = addr_reg;
  assign o_erase_len = remain_reg;
  assign o_run = run_reg;
  assign o_run_addr = run_addr_reg;
  assign o_sw_reset = rst_reg;
  always_ff @(posedge i_clk) begin
    if (rx_take && st_reg == S_PAY && cnt_reg < MAX_PAY) begin
      pay_reg[cnt_reg[3:0]] <= rx_data;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= S_SIZE;
      post_reg <= P_NONE;
      len_reg <= 8'h00;
      hsum_reg <= 8'h00;
      calc_reg <= 8'h00;
      cnt_reg <= 8'h00;
      stat_reg <= STS_OK;
      tx_reg <= 8'h00;
      tidx_reg <= 2'h0;
      addr_reg <= 32'h0000_0000;
      remain_reg <= 32'h0000_0000;
      active_reg <= 1'b0;
      fail_reg <= 1'b0;
      erase_reg <= 1'b0;
      run_reg <= 1'b0;
      rst_reg <= 1'b0;
      run_addr_reg <= 32'h0000_0000;
    end else begin
      run_reg <= 1'b0;
      rst_reg <= 1'b0;
      case (st_reg)
        S_SIZE: begin
          // leading zero padding never opens a packet
          if (rx_take && !rx_zero) begin
            len_reg <= rx_data;
            calc_reg <= 8'h00;
            cnt_reg <= 8'h00;
            st_reg <= S_SUM;
          end
        end
        S_SUM: begin
          if (rx_take) begin
            hsum_reg <= rx_data;
            st_reg <= (len_reg > HDR_LEN) ? S_PAY : S_EXEC;
          end
        end
        S_PAY: begin
          if (rx_take) begin
            calc_reg <= calc_reg + rx_data;
            cnt_reg <= cnt_reg + 8'h01;
            if (last_pay) st_reg <= S_EXEC;
          end
        end
        S_EXEC: begin
          tx_reg <= ACK_BYTE;
          post_reg <= P_NONE;
          st_reg <= S_ACK;
          cnt_reg <= 8'h01;
          if (!pkt_good) begin
            tx_reg <= NAK_BYTE;
          end else if (!cmd_ok) begin
            stat_reg <= STS_BAD_CMD;
          end else begin
            case (cmd)
              CMD_PING: stat_reg <= STS_OK;
              CMD_STAT: post_reg <= P_TXP;
              CMD_DNLD: begin
                addr_reg <= word_a;
                remain_reg <= word_b;
                active_reg <= 1'b0;
                erase_reg <= 1'b1;
                st_reg <= S_ERASE;
              end
              CMD_DATA: begin
                fail_reg <= 1'b0;
                if (active_reg) st_reg <= S_PROG;
                else stat_reg <= STS_BAD_SEQ;
              end
              CMD_RUN: begin
                run_addr_reg <= word_a;
                post_reg <= P_RUN;
              end
              CMD_RST: post_reg <= P_RST;
              default: stat_reg <= STS_BAD_CMD;
            endcase
          end
        end
        S_ERASE: begin
          // the answer waits for the whole erase
          if (i_erase_done) begin
            erase_reg <= 1'b0;
            stat_reg <= i_flash_fail ? STS_FAIL : STS_OK;
            active_reg <= !i_flash_fail && (remain_reg != '0);
            st_reg <= S_ACK;
          end
        end
        S_PROG: begin
          if (prog_hs) begin
            addr_reg <= addr_reg + 32'h0000_0001;
            remain_reg <= remain_reg - 32'h0000_0001;
            cnt_reg <= cnt_reg + 8'h01;
            if (i_flash_fail) fail_reg <= 1'b1;
          end else if (!prog_more) begin
            // the download count bounds the session
            active_reg <= (remain_reg != '0);
            stat_reg <= fail_reg ? STS_FAIL : STS_OK;
            st_reg <= S_ACK;
          end
        end
        S_ACK: begin
          if (tx_hs) begin
            st_reg <= S_SIZE;
            case (post_reg)
              P_RUN: run_reg <= 1'b1;
              P_RST: rst_reg <= 1'b1;
              P_TXP: begin
                tx_reg <= LEN_SHORT;
                tidx_reg <= 2'h0;
                st_reg <= S_TXP;
              end
              default: st_reg <= S_SIZE;
            endcase
          end
        end
        S_TXP: begin
          // size, sum of the one-byte payload, status, back to back
          if (tx_hs) begin
            tidx_reg <= tidx_reg + 2'h1;
            tx_reg <= stat_reg;
            if (tidx_reg == 2'h2) st_reg <= S_HRESP;
          end
        end
        S_HRESP: begin
          // ack or nak both close the exchange; a resend starts anew
          if (rx_take && !rx_zero) st_reg <= S_SIZE;
        end
        default: st_reg <= S_SIZE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ack_byte_a: assert property (st_reg == S_ACK |->
    tx_reg == ACK_BYTE || tx_reg == NAK_BYTE)
    else $error("answer byte is neither ack nor nak");
  nak_on_bad_a: assert property (st_reg == S_EXEC && !pkt_good |=>
    st_reg == S_ACK && tx_reg == NAK_BYTE)
    else $error("bad packet not answered by nak");
  addr_hold_a: assert property (st_reg == S_EXEC && !pkt_good |=>
    $stable(addr_reg) && $stable(remain_reg))
    else $error("program address moved on nak");
  ack_zero_wait_a: assert property (st_reg == S_HRESP && rx_take &&
    rx_zero |=> st_reg == S_HRESP)
    else $error("zero padding taken as response");
  run_after_ack_a: assert property (o_run |->
    $past(st_reg) == S_ACK && $past(tx_hs) &&
    $past(tx_reg) == ACK_BYTE)
    else $error("run issued without prior ack");
  reset_after_ack_a: assert property (o_sw_reset |->
    $past(st_reg) == S_ACK && $past(tx_hs))
    else $error("reset issued before ack sent");
  erase_hold_a: assert property (erase_reg && !i_erase_done |=>
    erase_reg && !tx_valid)
    else $error("answer sent before erase done");
  sequence stat_open_s;
    st_reg == S_TXP && tidx_reg == 2'h0 && tx_hs;
  endsequence
  status_pkt_a: assert property (stat_open_s |=>
    st_reg == S_TXP && tidx_reg == 2'h1 && tx_reg == stat_reg)
    else $error("status packet bytes out of order");
  status_tail_a: assert property (st_reg == S_TXP && tidx_reg == 2'h2 |->
    tx_reg == stat_reg)
    else $error("status byte missing at packet end");
  prog_end_a: assert property (st_reg == S_PROG && !prog_more &&
    !prog_hs && remain_reg == '0 |=> !active_reg)
    else $error("session open after count reached");
  data_seq_a: assert property (st_reg == S_EXEC && pkt_good && cmd_ok &&
    cmd == CMD_DATA && !active_reg |=> stat_reg == STS_BAD_SEQ
    && tx_reg == ACK_BYTE)
    else $error("stray data command mishandled");
endmodule
`default_nettype wire

// ### src/slpp_pkg.sv
package slpp_pkg;

  // framing and handshake bytes
  localparam logic [7:0] ACK_BYTE = 8'hCC;
  localparam logic [7:0] NAK_BYTE = 8'h33;
  localparam logic [7:0] HDR_LEN = 8'h02;
  localparam logic [7:0] MAX_PAY = 8'h09;
  localparam int PAY_DEPTH = 9;

  // command codes and their whole packet lengths
  localparam logic [7:0] CMD_PING = 8'h20;
  localparam logic [7:0] CMD_DNLD = 8'h21;
  localparam logic [7:0] CMD_RUN = 8'h22;
  localparam logic [7:0] CMD_STAT = 8'h23;
  localparam logic [7:0] CMD_DATA = 8'h24;
  localparam logic [7:0] CMD_RST = 8'h25;
  localparam logic [7:0] LEN_SHORT = 8'h03;
  localparam logic [7:0] LEN_RUN = 8'h07;
  localparam logic [7:0] LEN_LONG = 8'h0B;
  localparam logic [7:0] LEN_NONE = 8'h00;

  // status codes: values are arbitrary
  localparam logic [7:0] STS_OK = 8'h40;
  localparam logic [7:0] STS_BAD_CMD = 8'h41;
  localparam logic [7:0] STS_BAD_SEQ = 8'h42;
  localparam logic [7:0] STS_FAIL = 8'h43;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] data;
  } slpp_prog_t;

  typedef enum logic [1:0] {LINK_NONE, LINK_UART, LINK_SSI} slpp_link_t;

  // expected packet length of a command, LEN_NONE if unknown
  function automatic logic [7:0] cmd_len(input logic [7:0] cmd);
    case (cmd)
      CMD_PING, CMD_STAT, CMD_RST: cmd_len = LEN_SHORT;
      CMD_DNLD, CMD_DATA: cmd_len = LEN_LONG;
      CMD_RUN: cmd_len = LEN_RUN;
      default: cmd_len = LEN_NONE;
    endcase
  endfunction

endpackage

// ### src/slpp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module slpp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = AW'(DEPTH) == '0 ?
    (AW+1)'(DEPTH) : (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] cnt_reg;
  wire logic push;
  wire logic pop;

  assign o_wr_ready = (cnt_reg != FULL_CNT);
  assign o_rd_valid = (cnt_reg != '0);
  assign o_rd_data = mem_reg[rptr_reg];
  assign push = i_wr_valid && o_wr_ready;
  assign pop = o_rd_valid && i_rd_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wptr_reg <= bump(wptr_reg);
      if (pop) rptr_reg <= bump(rptr_reg);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cnt_reg <= FULL_CNT) else $error("fifo count past depth");
endmodule
`default_nettype wire

// ### src/slpp_link_sel.sv
`timescale 1ns/10ps
`default_nettype none
module slpp_link_sel
  import slpp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_uart_rx_valid,
  input wire logic [7:0] i_uart_rx_data,
  output logic o_uart_rx_ready,
  input wire logic i_ssi_rx_valid,
  input wire logic [7:0] i_ssi_rx_data,
  output logic o_ssi_rx_ready,
  output logic o_push_valid,
  output logic [7:0] o_push_data,
  input wire logic i_push_ready,
  output slpp_link_t o_link
);
  slpp_link_t link_reg;
  slpp_link_t link_next;
  wire logic pick_uart;

  // before the lock the asynchronous port wins a tie
  assign pick_uart = (link_reg == LINK_UART) ||
    (link_reg == LINK_NONE && i_uart_rx_valid);
  assign o_push_valid = pick_uart ? i_uart_rx_valid :
    (link_reg != LINK_UART) && i_ssi_rx_valid;
  assign o_push_data = pick_uart ? i_uart_rx_data : i_ssi_rx_data;
  // the locked-out port is drained and its bytes dropped
  assign o_uart_rx_ready = pick_uart ? i_push_ready :
    (link_reg == LINK_SSI);
  assign o_ssi_rx_ready = pick_uart ? (link_reg == LINK_UART) :
    i_push_ready;
  assign link_next = (link_reg != LINK_NONE) ? link_reg :
    i_uart_rx_valid ? LINK_UART :
    i_ssi_rx_valid ? LINK_SSI : LINK_NONE;
  assign o_link = link_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      link_reg <= LINK_NONE;
    end else begin
      link_reg <= link_next;
    end
  end

  link_lock_a: assert property (@(posedge i_clk) disable iff (i_rst)
    link_reg != LINK_NONE |=> $stable(link_reg))
    else $error("serial port lock changed");
endmodule
`default_nettype wire

// ### bench/slpp_host.sv
`timescale 1ns/10ps
`default_nettype none
module slpp_host (
  input wire logic i_clk,
  output logic o_valid,
  output logic [7:0] o_data,
  input wire logic i_ready,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_hang
);
  logic slow = 1'b0;

  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_tx_ready = 1'b1;
    o_hang = 1'b0;
  end

  // a slow host takes every other byte, so the device must hold its offer
  always @(posedge i_clk) begin
    o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // valid stays up across the packet; entered just after a rising edge
  task automatic send(input logic [7:0] q[$]);
    logic r;
    int n;
    o_valid <= 1'b1;
    foreach (q[i]) begin
      o_data <= q[i];
      n = 0;
      r = 1'b0;
      while (!r && n < 400) begin
        @(negedge i_clk);
        r = i_ready;
        @(posedge i_clk);
        n++;
      end
      if (!r) o_hang <= 1'b1;
    end
    o_valid <= 1'b0;
    // released data must not keep looking like the last byte
    o_data <= ~o_data;
  endtask

  // next non-zero byte taken from the device, zero fill skipped
  task automatic get(output logic [7:0] b);
    logic hit;
    int n;
    hit = 1'b0;
    n = 0;
    b = 8'h00;
    while (!hit && n < 2000) begin
      @(negedge i_clk);
      hit = i_tx_valid && o_tx_ready && (i_tx_data != 8'h00);
      b = i_tx_data;
      @(posedge i_clk);
      n++;
    end
    if (!hit) o_hang <= 1'b1;
  endtask

  // answer a device packet, zero padded as a clocked link needs
  task automatic reply(input logic [7:0] r);
    send('{8'h00, 8'h00, r});
  endtask
endmodule
`default_nettype wire

// ### bench/slpp_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module slpp_top_tb
  import slpp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic u_valid, u_ready, s_ready, ut_valid, st_valid, hang;
  logic [7:0] u_data, tx_data;
  logic tx_ready;
  logic s_valid = 1'b0;
  logic [7:0] s_data = 8'h00;
  logic er_req, run, swr, pg_valid;
  logic [31:0] er_addr, er_len, run_addr;
  logic er_done = 1'b0;
  logic pg_ready = 1'b0;
  logic fail = 1'b0;
  slpp_prog_t pg;
  slpp_link_t link;
  int errors = 0;
  int check_count = 0;
  int ecnt = 0;
  int ssi_tx = 0;
  logic erased = 1'b0;
  logic run_seen = 1'b0;
  logic swr_seen = 1'b0;
  logic [31:0] run_at = 32'h0;
  slpp_prog_t wr_q[$];

  initial begin
    forever #25 clk = ~clk;
  end

  slpp_top #(.FIFO_DEPTH(4)) dut (
    .i_clk(clk), .i_rst(rst),
    .i_uart_rx_valid(u_valid), .i_uart_rx_data(u_data),
    .o_uart_rx_ready(u_ready),
    .i_ssi_rx_valid(s_valid), .i_ssi_rx_data(s_data),
    .o_ssi_rx_ready(s_ready),
    .o_uart_tx_valid(ut_valid), .o_ssi_tx_valid(st_valid),
    .o_tx_data(tx_data), .i_tx_ready(tx_ready),
    .o_erase_req(er_req), .o_erase_addr(er_addr),
    .o_erase_len(er_len), .i_erase_done(er_done),
    .o_prog_valid(pg_valid), .o_prog(pg), .i_prog_ready(pg_ready),
    .i_flash_fail(fail), .o_run(run), .o_run_addr(run_addr),
    .o_sw_reset(swr), .o_link(link)
  );

  slpp_host h (
    .i_clk(clk), .o_valid(u_valid), .o_data(u_data), .i_ready(u_ready),
    .i_tx_valid(ut_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
    .o_hang(hang)
  );

  ////////////////////////////////////////////////////////////////////////
  // flash stand-in: erase takes 21 cycles, writes are taken every other one
  always @(posedge clk) begin
    er_done <= 1'b0;
    pg_ready <= ~pg_ready;
    if (er_req && !er_done) begin
      ecnt <= ecnt + 1;
      if (ecnt == 20) begin
        er_done <= 1'b1;
        erased <= 1'b1;
        ecnt <= 0;
      end
    end
    if (pg_valid && pg_ready) wr_q.push_back(pg);
    if (run) begin
      run_seen <= 1'b1;
      run_at <= run_addr;
    end
    if (swr) swr_seen <= 1'b1;
    if (st_valid) ssi_tx++;
  end

  always @(posedge hang) begin
    errors++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // size counts size and sum bytes; sum wraps at 8 bits
  task automatic pkt(input logic [7:0] p[$], input logic [7:0] spoil = 8'h00);
    logic [7:0] s;
    logic [7:0] q[$];
    s = 8'h00;
    foreach (p[i]) s += p[i];
    q = p;
    q.push_front(s ^ spoil);
    q.push_front(8'(p.size() + 2));
    h.send(q);
  endtask

  task automatic expect_byte(input logic [7:0] exp);
    logic [7:0] b;
    h.get(b);
    check({24'h0, b}, {24'h0, exp});
  endtask

  task automatic status(input logic [7:0] exp);
    pkt('{CMD_STAT});
    expect_byte(ACK_BYTE);
    expect_byte(LEN_SHORT);
    expect_byte(exp);
    expect_byte(exp);
    h.reply(ACK_BYTE);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_ping;
    h.send('{8'h00, LEN_SHORT, CMD_PING, CMD_PING});
    expect_byte(ACK_BYTE);
    check(32'(link), 32'(LINK_UART));
    status(STS_OK);
  endtask

  // the other port is drained and never answered once async is locked
  task automatic t_lock;
    s_valid <= 1'b1;
    s_data <= LEN_SHORT;
    pkt('{CMD_PING});
    expect_byte(ACK_BYTE);
    check(s_ready, 1'b1);
    check(ssi_tx, 0);
    s_valid <= 1'b0;
  endtask

  task automatic t_faults;
    pkt('{CMD_PING}, 8'h01);
    expect_byte(NAK_BYTE);
    h.send('{8'h02, 8'h00});
    expect_byte(NAK_BYTE);
    pkt('{CMD_DNLD});
    expect_byte(ACK_BYTE);
    status(STS_BAD_CMD);
    pkt('{8'h7E});
    expect_byte(ACK_BYTE);
    status(STS_BAD_CMD);
    pkt('{CMD_DATA, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
    expect_byte(ACK_BYTE);
    status(STS_BAD_SEQ);
    pkt('{CMD_PING});
    expect_byte(ACK_BYTE);
    status(STS_OK);
  endtask

  // ten bytes at 0x1000, so the second data packet overshoots the count
  task automatic t_download(input logic f);
    erased <= 1'b0;
    fail <= f;
    pkt('{CMD_DNLD, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0A});
    expect_byte(ACK_BYTE);
    check(erased, 1'b1);
    check(er_addr, 32'h00001000);
    check(er_len, 32'h0000000A);
    fail <= 1'b0;
    status(f ? STS_FAIL : STS_OK);
  endtask

  task automatic t_data;
    logic [7:0] e;
    wr_q.delete();
    h.slow = 1'b1;
    pkt('{CMD_DATA, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7});
    expect_byte(ACK_BYTE);
    status(STS_OK);
    pkt('{CMD_DATA, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7},
        8'h80);
    expect_byte(NAK_BYTE);
    check(wr_q.size(), 8);
    pkt('{CMD_DATA, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7});
    expect_byte(ACK_BYTE);
    check(wr_q.size(), 10);
    foreach (wr_q[i]) begin
      e = (i < 8) ? 8'(8'hA0 + i) : 8'(8'hB8 + i);
      check(wr_q[i].addr, 32'(32'h1000 + i));
      check({24'h0, wr_q[i].data}, {24'h0, e});
    end
    h.slow = 1'b0;
    status(STS_OK);
  endtask

  // the pulse may only follow the acknowledge handshake
  task automatic t_run;
    logic [7:0] b;
    pkt('{CMD_RUN, 8'h12, 8'h34, 8'h56, 8'h78});
    h.get(b);
    check(run_seen, 1'b0);
    check({24'h0, b}, {24'h0, ACK_BYTE});
    repeat (3) @(posedge clk);
    check(run_seen, 1'b1);
    check(run_at, 32'h12345678);
  endtask

  task automatic t_reset;
    logic [7:0] b;
    pkt('{CMD_RST});
    h.get(b);
    check(swr_seen, 1'b0);
    check({24'h0, b}, {24'h0, ACK_BYTE});
    repeat (3) @(posedge clk);
    check(swr_seen, 1'b1);
  endtask

  // a mid-run reset frees the port lock, so the clocked port may win
  task automatic t_ssi;
    logic [7:0] q[$];
    logic [7:0] b;
    logic r;
    int n;
    q = '{LEN_SHORT, CMD_PING, CMD_PING};
    b = 8'h00;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'(link), 32'(LINK_NONE));
    s_valid <= 1'b1;
    foreach (q[i]) begin
      s_data <= q[i];
      r = 1'b0;
      n = 0;
      while (!r && n < 400) begin
        @(negedge clk);
        r = s_ready;
        @(posedge clk);
        n++;
      end
      check(r, 1'b1);
    end
    s_valid <= 1'b0;
    s_data <= ~s_data;
    r = 1'b0;
    n = 0;
    while (!r && n < 400) begin
      @(negedge clk);
      r = st_valid && tx_ready;
      b = tx_data;
      @(posedge clk);
      n++;
    end
    check(r, 1'b1);
    check({24'h0, b}, {24'h0, ACK_BYTE});
    check(32'(link), 32'(LINK_SSI));
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_ping();
    t_lock();
    t_faults();
    t_download(1'b1);
    t_download(1'b0);
    t_data();
    t_run();
    t_reset();
    check(ssi_tx, 0);
    t_ssi();
    test_done();
  end
endmodule
`default_nettype wire
